// *** design/pcu_pkg.sv ***
// Package for the protection unit and cache maintenance block
`default_nettype none
package pcu_pkg;
    // ------------------------------------------------------------
    // Coprocessor register numbers
    // ------------------------------------------------------------
    localparam logic [3:0] REG_PERM = 4'h5;
    localparam logic [3:0] REG_REGION = 4'h6;
    localparam logic [3:0] REG_CACHEOP = 4'h7;
    localparam logic [3:0] REG_LOCK = 4'h9;
    localparam logic [3:0] REG_LEGACY = 4'hF;
    localparam logic [3:0] REG_CTRL = 4'h1;
    // ------------------------------------------------------------
    // Secondary opcode values
    // ------------------------------------------------------------
    localparam logic [2:0] OP2_DATA = 3'h0;
    localparam logic [2:0] OP2_INSTR = 3'h1;
    localparam logic [2:0] OP2_ENTRY = 3'h2;
    localparam logic [2:0] OP2_WFI = 3'h4;
    localparam logic [2:0] OP2_DRAIN = 3'h4;
    // ------------------------------------------------------------
    // Cache operation selectors
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_WFI = 4'h0;
    localparam logic [3:0] SEL_IFLUSH = 4'h5;
    localparam logic [3:0] SEL_DFLUSH = 4'h6;
    localparam logic [3:0] SEL_LEG_WFI = 4'h8;
    localparam logic [3:0] SEL_CLEAN = 4'hA;
    localparam logic [3:0] SEL_PREF = 4'hD;
    localparam logic [3:0] SEL_CLFL = 4'hE;
    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int AREAS = 8;
    localparam int AP_W = 2;
    localparam int PERM_W = AREAS * AP_W;
    localparam int BASE_LSB = 12;
    localparam int SIZE_LSB = 1;
    localparam int SIZE_W = 5;
    localparam int EN_BIT = 0;
    localparam int IDX_LSB = 26;
    localparam int IDX_W = 6;
    localparam int SEG_LSB = 4;
    localparam int SEG_W = 2;
    localparam int LINE_LSB = 6;
    localparam int LOAD_BIT = 31;
    localparam int PU_EN_BIT = 0;
    localparam logic [4:0] SIZE_MIN = 5'h0B;
    localparam logic [31:0] REGION_MASK = 32'hFFFFF03F;
    localparam logic [31:0] LOCK_MASK = 32'h8000003F;
    localparam logic [31:0] ZERO_W = 32'h00000000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AP_NONE = 2'b00,
        AP_PRIV = 2'b01,
        AP_USER_RO = 2'b10,
        AP_FULL = 2'b11
    } pcu_ap_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WFI = 2'b01,
        ST_DRAIN = 2'b10
    } pcu_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] crn;
        logic [3:0] region_select_field;
        logic [2:0] op2;
        logic [31:0] data;
    } pcu_xfer_t;
    typedef struct packed {
        logic valid;
        logic [2:0] kind;
        logic [31:0] arg;
    } pcu_cop_t;
    localparam logic [2:0] K_IFLUSH_ALL = 3'h0;
    localparam logic [2:0] K_IFLUSH_ONE = 3'h1;
    localparam logic [2:0] K_DFLUSH_ALL = 3'h2;
    localparam logic [2:0] K_DFLUSH_ONE = 3'h3;
    localparam logic [2:0] K_DCLEAN_ONE = 3'h4;
    localparam logic [2:0] K_DCLFL_ONE = 3'h5;
    localparam logic [2:0] K_IPREFETCH = 3'h6;
endpackage
`default_nettype wire

// *** design/pcu_top.sv ***
// Protection unit registers and cache maintenance operations
// What this block does
// - op2 0 data, 1 instruction permissions
// - Eight 2-bit area permission fields
// - Encoding: none, priv, user-RO, full
// - Regions ignored while unit disabled
// - Reset clears region enable bits, not base or size
// - Eight regions, op2 set, field picks
// - Base 31:12, size 5:1, enable 0
// - Size codes below 01011 reserved
// - c5/c6 flush whole or single entry
// - Clean, clean-flush, prefetch selectors
// - Cache-op reads return zero
// - Entry index 31:26, segment 5:4
// - Prefetch line 31:6, segment 5:4
// - Wait-for-interrupt freezes clocks until wake
// - Interrupts wake regardless of masking
// - Debug wakes only when permitted
// - Pending interrupt taken before next instruction
// - Drain holds wait until buffer empty
// - Lockdown op2 0 data, 1 instruction
// - Lockdown load bit 31, index 5:0
// - Control bit 0 enables, reset clear
`default_nettype none
module pcu_top
    import pcu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire pcu_xfer_t xfer_in,
    input wire logic wbuf_empty_in,
    input wire logic fast_irq_in_n,
    input wire logic normal_irq_in_n,
    input wire logic ext_debug_request_in,
    input wire logic debug_permit_in,
    input wire logic dbg_req_bit_in,
    output logic [31:0] rdata_out,
    output logic coproc_wait_n,
    output logic clk_freeze_out,
    output logic debug_entry_out,
    output logic pu_enable_out,
    output pcu_cop_t cop_out,
    output logic [PERM_W-1:0] dperm_out,
    output logic [PERM_W-1:0] iperm_out,
    output logic [AREAS-1:0] dregion_act_out,
    output logic [AREAS-1:0] iregion_act_out
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic fiq_act;
    logic irq_act;
    logic edbg_act;
    logic debug_permit_in_act;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            // Idle levels: interrupts high, debug request and permit low
            pin_s1_ff <= 4'hC;
            pin_s2_ff <= 4'hC;
        end else begin
            pin_s1_ff <= {fast_irq_in_n, normal_irq_in_n, ext_debug_request_in, debug_permit_in};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    assign fiq_act = ~pin_s2_ff[3];
    assign irq_act = ~pin_s2_ff[2];
    assign edbg_act = pin_s2_ff[1];
    assign debug_permit_in_act = pin_s2_ff[0];

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input pcu_xfer_t x, input logic [3:0] crn,
                                 input logic [3:0] region_select_field, input logic [2:0] op2);
        hit = x.crn == crn && x.region_select_field == region_select_field && x.op2 == op2;
    endfunction

    function automatic logic size_ok(input logic [31:0] r);
        size_ok = r[SIZE_LSB +: SIZE_W] >= SIZE_MIN;
    endfunction

    logic wr;
    assign wr = xfer_in.wr;

    // ------------------------------------------------------------
    // Permission registers
    // ------------------------------------------------------------
    logic [PERM_W-1:0] dperm_ff;
    logic [PERM_W-1:0] iperm_ff;

    always_ff @(posedge mclk_in) begin
        if (wr && hit(xfer_in, REG_PERM, 4'h0, OP2_DATA)) begin
            dperm_ff <= xfer_in.data[PERM_W-1:0];
        end
        if (wr && hit(xfer_in, REG_PERM, 4'h0, OP2_INSTR)) begin
            iperm_ff <= xfer_in.data[PERM_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Control enable and lockdown registers
    // ------------------------------------------------------------
    logic pu_en_ff;
    logic [31:0] dlock_ff;
    logic [31:0] ilock_ff;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pu_en_ff <= 1'b0;
        end else if (wr && hit(xfer_in, REG_CTRL, 4'h0, OP2_DATA)) begin
            pu_en_ff <= xfer_in.data[PU_EN_BIT];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            dlock_ff <= ZERO_W;
            ilock_ff <= ZERO_W;
        end else begin
            if (wr && hit(xfer_in, REG_LOCK, 4'h0, OP2_DATA)) begin
                dlock_ff <= xfer_in.data & LOCK_MASK;
            end
            if (wr && hit(xfer_in, REG_LOCK, 4'h0, OP2_INSTR)) begin
                ilock_ff <= xfer_in.data & LOCK_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Region registers
    // ------------------------------------------------------------
    logic [31:0] dreg_ff [AREAS];
    logic [31:0] ireg_ff [AREAS];
    logic [AREAS-1:0] dact_ff;
    logic [AREAS-1:0] iact_ff;

    genvar g;
    generate
        for (g = 0; g < AREAS; g++) begin : g_region
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    dreg_ff[g][EN_BIT] <= 1'b0;
                    ireg_ff[g][EN_BIT] <= 1'b0;
                end else begin
                    if (wr && hit(xfer_in, REG_REGION, 4'(g), OP2_DATA)) begin
                        dreg_ff[g] <= xfer_in.data & REGION_MASK;
                    end
                    if (wr && hit(xfer_in, REG_REGION, 4'(g), OP2_INSTR)) begin
                        ireg_ff[g] <= xfer_in.data & REGION_MASK;
                    end
                end
            end
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    dact_ff[g] <= 1'b0;
                    iact_ff[g] <= 1'b0;
                end else begin
                    // Region live only with unit on and legal size
                    dact_ff[g] <= pu_en_ff && dreg_ff[g][EN_BIT] && size_ok(dreg_ff[g]);
                    iact_ff[g] <= pu_en_ff && ireg_ff[g][EN_BIT] && size_ok(ireg_ff[g]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = ZERO_W;
        if (xfer_in.crn == REG_PERM && xfer_in.op2 == OP2_DATA) begin
            nxt_rdata = {16'h0000, dperm_ff};
        end else if (xfer_in.crn == REG_PERM && xfer_in.op2 == OP2_INSTR) begin
            nxt_rdata = {16'h0000, iperm_ff};
        end else if (xfer_in.crn == REG_REGION && xfer_in.op2 == OP2_DATA) begin
            nxt_rdata = dreg_ff[xfer_in.region_select_field[2:0]];
        end else if (xfer_in.crn == REG_REGION && xfer_in.op2 == OP2_INSTR) begin
            nxt_rdata = ireg_ff[xfer_in.region_select_field[2:0]];
        end else if (xfer_in.crn == REG_LOCK && xfer_in.op2 == OP2_DATA) begin
            nxt_rdata = dlock_ff;
        end else if (xfer_in.crn == REG_LOCK && xfer_in.op2 == OP2_INSTR) begin
            nxt_rdata = ilock_ff;
        end else if (xfer_in.crn == REG_CTRL) begin
            nxt_rdata = {31'h00000000, pu_en_ff};
        end
        // Cache-op register reads fall through to zero
    end

    logic [31:0] rdata_ff;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_ff <= ZERO_W;
        end else if (xfer_in.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Cache operation decode
    // ------------------------------------------------------------
    pcu_cop_t nxt_cop;
    pcu_cop_t cop_ff;
    logic is_op7;
    assign is_op7 = wr && xfer_in.crn == REG_CACHEOP;

    always_comb begin
        nxt_cop = '0;
        if (is_op7) begin
            nxt_cop.valid = 1'b1;
            nxt_cop.arg = xfer_in.data & 32'hFC000030;
            if (xfer_in.region_select_field == SEL_IFLUSH && xfer_in.op2 == OP2_DATA) begin
                nxt_cop.kind = K_IFLUSH_ALL;
            end else if (xfer_in.region_select_field == SEL_IFLUSH && xfer_in.op2 == OP2_ENTRY) begin
                nxt_cop.kind = K_IFLUSH_ONE;
            end else if (xfer_in.region_select_field == SEL_DFLUSH && xfer_in.op2 == OP2_DATA) begin
                nxt_cop.kind = K_DFLUSH_ALL;
            end else if (xfer_in.region_select_field == SEL_DFLUSH && xfer_in.op2 == OP2_ENTRY) begin
                nxt_cop.kind = K_DFLUSH_ONE;
            end else if (xfer_in.region_select_field == SEL_CLEAN && xfer_in.op2 == OP2_ENTRY) begin
                nxt_cop.kind = K_DCLEAN_ONE;
            end else if (xfer_in.region_select_field == SEL_CLFL && xfer_in.op2 == OP2_ENTRY) begin
                nxt_cop.kind = K_DCLFL_ONE;
            end else if (xfer_in.region_select_field == SEL_PREF && xfer_in.op2 == OP2_INSTR) begin
                nxt_cop.kind = K_IPREFETCH;
                nxt_cop.arg = xfer_in.data & 32'hFFFFFFF0;
            end else begin
                nxt_cop.valid = 1'b0;
            end
            if (nxt_cop.kind == K_IFLUSH_ALL || nxt_cop.kind == K_DFLUSH_ALL) begin
                nxt_cop.arg = ZERO_W;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cop_ff <= '0;
        end else begin
            cop_ff <= nxt_cop;
        end
    end

    // ------------------------------------------------------------
    // Wait-for-interrupt and drain state machine
    // ------------------------------------------------------------
    pcu_state_t state_ff;
    pcu_state_t nxt_state;
    logic wfi_req;
    logic drain_req;
    logic wake_irq;
    logic wake_dbg;
    logic wait_ff;
    logic freeze_ff;
    logic dbg_entry_ff;

    assign wfi_req = (is_op7 && xfer_in.region_select_field == SEL_WFI && xfer_in.op2 == OP2_WFI)
        || (wr && hit(xfer_in, REG_LEGACY, SEL_LEG_WFI, OP2_ENTRY));
    assign drain_req = is_op7 && xfer_in.region_select_field == SEL_CLEAN && xfer_in.op2 == OP2_DRAIN;
    assign wake_irq = fiq_act || irq_act;
    assign wake_dbg = debug_permit_in_act && (edbg_act || dbg_req_bit_in);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (wfi_req) begin
                    nxt_state = ST_WFI;
                end else if (drain_req) begin
                    nxt_state = ST_DRAIN;
                end
            end
            ST_WFI: begin
                if (wake_irq || wake_dbg) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_DRAIN: begin
                if (wbuf_empty_in) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_ff <= ST_RUN;
            wait_ff <= 1'b0;
            freeze_ff <= 1'b0;
            dbg_entry_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_state == ST_DRAIN;
            freeze_ff <= nxt_state == ST_WFI;
            // Debug wake steers core into debug state first
            dbg_entry_ff <= state_ff == ST_WFI && wake_dbg;
        end
    end

    assign coproc_wait_n = ~wait_ff;
    assign clk_freeze_out = freeze_ff;
    assign debug_entry_out = dbg_entry_ff;
    assign pu_enable_out = pu_en_ff;
    assign cop_out = cop_ff;
    assign dperm_out = dperm_ff;
    assign iperm_out = iperm_ff;
    assign dregion_act_out = dact_ff;
    assign iregion_act_out = iact_ff;
    assign rdata_out = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_perm_store;
        @(posedge mclk_in) disable iff (rst_in)
        wr && hit(xfer_in, REG_PERM, 4'h0, OP2_INSTR) |=> iperm_out == $past(xfer_in.data[15:0]);
    endproperty
    a_perm_store: assert property (p_perm_store) else $error("instr perm not stored");

    property p_region_disabled;
        @(posedge mclk_in) disable iff (rst_in)
        !pu_en_ff |=> dregion_act_out == 8'h00 && iregion_act_out == 8'h00;
    endproperty
    a_region_disabled: assert property (p_region_disabled) else $error("region live while off");

    property p_reset_en;
        @(posedge mclk_in) rst_in |=> !dreg_ff[0][0] && !ireg_ff[7][0] && !pu_enable_out;
    endproperty
    a_reset_en: assert property (p_reset_en) else $error("enable not cleared");

    property p_region_fmt;
        @(posedge mclk_in) disable iff (rst_in)
        wr && hit(xfer_in, REG_REGION, 4'h3, OP2_DATA) |=> dreg_ff[3][11:6] == 6'h00;
    endproperty
    a_region_fmt: assert property (p_region_fmt) else $error("unused region bits kept");

    property p_flush;
        @(posedge mclk_in) disable iff (rst_in)
        is_op7 && xfer_in.region_select_field == SEL_DFLUSH && xfer_in.op2 == OP2_ENTRY
        |=> cop_out.valid && cop_out.kind == K_DFLUSH_ONE;
    endproperty
    a_flush: assert property (p_flush) else $error("dcache entry flush missing");

    property p_prefetch;
        @(posedge mclk_in) disable iff (rst_in)
        is_op7 && xfer_in.region_select_field == SEL_PREF && xfer_in.op2 == OP2_INSTR
        |=> cop_out.kind == K_IPREFETCH && cop_out.arg[31:6] == $past(xfer_in.data[31:6]);
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch address lost");

    property p_wfi;
        @(posedge mclk_in) disable iff (rst_in)
        state_ff == ST_RUN && wfi_req |=> clk_freeze_out;
    endproperty
    a_wfi: assert property (p_wfi) else $error("clocks not frozen");

    property p_wake;
        @(posedge mclk_in) disable iff (rst_in)
        state_ff == ST_WFI && wake_irq |=> !clk_freeze_out;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt did not wake");

    property p_dbg_block;
        @(posedge mclk_in) disable iff (rst_in)
        state_ff == ST_WFI && !debug_permit_in_act && !wake_irq |=> clk_freeze_out;
    endproperty
    a_dbg_block: assert property (p_dbg_block) else $error("woke without permit");

    property p_drain;
        @(posedge mclk_in) disable iff (rst_in)
        state_ff == ST_DRAIN && !wbuf_empty_in |=> !coproc_wait_n;
    endproperty
    a_drain: assert property (p_drain) else $error("wait dropped early");

    property p_lock;
        @(posedge mclk_in) disable iff (rst_in)
        wr && hit(xfer_in, REG_LOCK, 4'h0, OP2_INSTR) |=> ilock_ff[30:6] == 25'h0;
    endproperty
    a_lock: assert property (p_lock) else $error("lockdown reserved bits kept");
endmodule
`default_nettype wire

// *** testbench/pcu_core_model.sv ***
// Model of the integer core issuing coprocessor transfers
`default_nettype none
module pcu_core_model
    import pcu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [31:0] rdata_in,
    output var pcu_xfer_t xfer_out,
    output var logic wbuf_empty_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        xfer_out = '0;
        wbuf_empty_out = 1'b1;
    end
    // One transfer, held over its sampling edge only
    task automatic put(input logic w, input logic [3:0] n, input logic [3:0] m,
                       input logic [2:0] o, input logic [31:0] d);
        @(posedge mclk_in);
        xfer_out <= '{wr: w, rd: !w, crn: n, region_select_field: m, op2: o, data: d};
        @(posedge mclk_in);
        xfer_out.wr <= 1'b0;
        xfer_out.rd <= 1'b0;
        xfer_out.data <= ~d;
    endtask
    task automatic cp_rd(input logic [3:0] n, input logic [3:0] m, input logic [2:0] o,
                         output logic [31:0] q);
        put(1'b0, n, m, o, 32'h00000000);
        @(posedge mclk_in);
        #1 q = rdata_in;
    endtask
    // Write buffer drains at a pace the bench chooses
    task automatic set_wbuf(input logic v);
        @(posedge mclk_in);
        wbuf_empty_out <= v;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_pcu_top.sv ***
// Self-checking bench for the protection and cache maintenance block
`default_nettype none
module tb_pcu_top
    import pcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in, rst_in, fiq_n, irq_n, edbg, dpermit, dbit, wbuf_empty;
    pcu_xfer_t xfer;
    pcu_cop_t cop;
    logic [31:0] rdata;
    logic wait_n, freeze, dbg_entry, pu_en;
    logic [PERM_W-1:0] dperm, iperm;
    logic [AREAS-1:0] dact, iact;
    int n_fail = 0;
    int n_tests = 0;
    pcu_top u_pcu_top (.mclk_in(mclk_in), .rst_in(rst_in), .xfer_in(xfer),
        .wbuf_empty_in(wbuf_empty), .fast_irq_in_n(fiq_n), .normal_irq_in_n(irq_n),
        .ext_debug_request_in(edbg), .debug_permit_in(dpermit), .dbg_req_bit_in(dbit),
        .rdata_out(rdata), .coproc_wait_n(wait_n), .clk_freeze_out(freeze),
        .debug_entry_out(dbg_entry), .pu_enable_out(pu_en), .cop_out(cop),
        .dperm_out(dperm), .iperm_out(iperm), .dregion_act_out(dact), .iregion_act_out(iact));
    pcu_core_model u_pcu_core_model (.mclk_in(mclk_in), .rdata_in(rdata), .xfer_out(xfer),
        .wbuf_empty_out(wbuf_empty));
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] n, input logic [3:0] m, input logic [2:0] o,
                      input logic [31:0] d);
        u_pcu_core_model.put(1'b1, n, m, o, d);
    endtask
    task automatic t_perm();
        logic [31:0] q;
        wr(REG_PERM, 4'h0, OP2_DATA, 32'h0000E41B);
        wr(REG_PERM, 4'h0, OP2_INSTR, 32'h00001BE4);
        u_pcu_core_model.cp_rd(REG_PERM, 4'h0, OP2_DATA, q);
        chk(q[15:0], 16'hE41B, "data perm read");
        u_pcu_core_model.cp_rd(REG_PERM, 4'h0, OP2_INSTR, q);
        chk(q[15:0], 16'h1BE4, "instr perm read");
        chk({iperm, dperm}, 32'h1BE4E41B, "perm fields");
    endtask
    task automatic t_region();
        logic [31:0] q;
        wr(REG_REGION, 4'h2, OP2_DATA, 32'h00002019);
        wr(REG_REGION, 4'h5, OP2_INSTR, 32'hFFFFFFD5);
        wr(REG_REGION, 4'h7, OP2_INSTR, 32'h00000017);
        repeat (3) @(posedge mclk_in);
        #1 chk({dact, iact}, 16'h0000, "regions while off");
        wr(REG_CTRL, 4'h0, OP2_DATA, 32'h00000001);
        repeat (3) @(posedge mclk_in);
        #1 chk({pu_en, dact, iact}, {1'b1, 8'h04, 8'h80}, "regions live");
        u_pcu_core_model.cp_rd(REG_REGION, 4'h2, OP2_DATA, q);
        chk(q, 32'h00002019, "data region read");
        u_pcu_core_model.cp_rd(REG_REGION, 4'h5, OP2_INSTR, q);
        chk(q, 32'hFFFFF015, "instr region read");
        wr(REG_CTRL, 4'h0, OP2_DATA, 32'h00000000);
        repeat (3) @(posedge mclk_in);
        #1 chk({pu_en, dact, iact}, 17'h0, "unit off again");
    endtask
    task automatic t_reset();
        logic [31:0] q;
        wr(REG_REGION, 4'h1, OP2_DATA, 32'h00004019);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        #1 chk({wait_n, freeze, pu_en, cop.valid}, 4'h8, "mid-run reset");
        u_pcu_core_model.cp_rd(REG_REGION, 4'h1, OP2_DATA, q);
        chk(q[0], 1'b0, "region enable cleared");
        wr(REG_CTRL, 4'h0, OP2_DATA, 32'h00000001);
        repeat (3) @(posedge mclk_in);
        #1 chk({pu_en, dact, iact}, {1'b1, 16'h0000}, "regions off after reset");
        wr(REG_CTRL, 4'h0, OP2_DATA, 32'h00000000);
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic t_cacheop();
        logic [3:0] sm [7] = '{SEL_IFLUSH, SEL_IFLUSH, SEL_DFLUSH, SEL_DFLUSH, SEL_CLEAN,
                               SEL_CLFL, SEL_PREF};
        logic [2:0] so [7] = '{3'h0, 3'h2, 3'h0, 3'h2, 3'h2, 3'h2, 3'h1};
        logic [2:0] ke [7] = '{K_IFLUSH_ALL, K_IFLUSH_ONE, K_DFLUSH_ALL, K_DFLUSH_ONE,
                               K_DCLEAN_ONE, K_DCLFL_ONE, K_IPREFETCH};
        logic [31:0] ae [7] = '{32'h0, 32'hFC000030, 32'h0, 32'hFC000030, 32'hFC000030,
                                32'hFC000030, 32'hFFFFFFF0};
        logic [31:0] q;
        for (int i = 0; i < 7; i++) begin
            wr(REG_CACHEOP, sm[i], so[i], 32'hFFFFFFFF);
            #1 chk({cop.valid, cop.kind}, {1'b1, ke[i]}, "cache op kind");
            chk(cop.arg, ae[i], "cache op arg");
            @(posedge mclk_in);
            #1 chk(cop.valid, 1'b0, "cache op pulse");
        end
        wr(REG_CACHEOP, 4'h3, 3'h0, 32'h00000000);
        #1 chk(cop.valid, 1'b0, "unknown selector");
        u_pcu_core_model.cp_rd(REG_CACHEOP, SEL_CLEAN, OP2_ENTRY, q);
        chk(q, 32'h00000000, "cache op read");
    endtask
    task automatic t_drain();
        u_pcu_core_model.set_wbuf(1'b0);
        wr(REG_CACHEOP, SEL_CLEAN, OP2_DRAIN, 32'h00000000);
        @(posedge mclk_in);
        #1 chk(wait_n, 1'b0, "drain stall");
        repeat (6) @(posedge mclk_in);
        #1 chk(wait_n, 1'b0, "stall holds");
        u_pcu_core_model.set_wbuf(1'b1);
        repeat (2) @(posedge mclk_in);
        #1 chk(wait_n, 1'b1, "stall ends");
    endtask
    task automatic t_wfi();
        logic seen;
        seen = 1'b0;
        wr(REG_CACHEOP, SEL_WFI, OP2_WFI, 32'h00000000);
        @(posedge mclk_in);
        edbg <= 1'b1;
        repeat (8) @(posedge mclk_in);
        #1 chk(freeze, 1'b1, "debug without permit");
        dpermit <= 1'b1;
        repeat (8) begin
            @(posedge mclk_in);
            #1 seen = seen | dbg_entry;
        end
        chk({seen, freeze}, 2'b10, "debug wake");
        edbg <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            wr(s[0] ? REG_LEGACY : REG_CACHEOP, s[0] ? SEL_LEG_WFI : SEL_WFI,
               s[0] ? OP2_ENTRY : OP2_WFI, 32'h00000000);
            @(posedge mclk_in);
            irq_n <= (s != 0);
            fiq_n <= (s != 1);
            dbit <= (s == 2);
            #1 chk(freeze, 1'b1, "frozen");
            repeat (5) @(posedge mclk_in);
            #1 chk(freeze, 1'b0, "woken");
            irq_n <= 1'b1;
            fiq_n <= 1'b1;
            dbit <= 1'b0;
        end
    endtask
    task automatic t_lock();
        logic [31:0] q;
        u_pcu_core_model.cp_rd(REG_LOCK, 4'h0, OP2_DATA, q);
        chk(q, 32'h00000000, "lockdown reset");
        wr(REG_LOCK, 4'h0, OP2_DATA, 32'hFFFFFFFF);
        wr(REG_LOCK, 4'h0, OP2_INSTR, 32'h80000015);
        u_pcu_core_model.cp_rd(REG_LOCK, 4'h0, OP2_DATA, q);
        chk(q, 32'h8000003F, "data lockdown");
        u_pcu_core_model.cp_rd(REG_LOCK, 4'h0, OP2_INSTR, q);
        chk(q, 32'h80000015, "instr lockdown");
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge mclk_in);
        n_fail++;
        wrap_up();
    end
    initial begin
        rst_in = 1'b1;
        fiq_n = 1'b1;
        irq_n = 1'b1;
        edbg = 1'b0;
        dpermit = 1'b0;
        dbit = 1'b0;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        #1 chk({wait_n, freeze, pu_en, dact, iact}, 19'h40000, "reset state");
        t_perm();
        t_region();
        t_reset();
        t_cacheop();
        t_drain();
        t_wfi();
        t_lock();
        wrap_up();
    end
endmodule
`default_nettype wire
